// file: flash_host_pkg.sv
// Constants and types shared by the flash host controller files.
// Behaviour
// - Chip erase: write 30H then D0H
// - Poll status 70H until ready before program/erase
// - Program: 40H or 10H, then data, same address
// - Write FFH before reading array again
// - Suspend: write B0H, poll until ready
// - While suspended read array, resume with D0H
// - Issue array-read after any program or erase; the sequencer goes back to idle, and array-read needs an OP_READ request
// - Writes happen only with both enables low
`default_nettype none
package flash_host_pkg;

    // ----------------------------------------------------------------
    // Flash command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

    // ----------------------------------------------------------------
    // Flash status byte bits
    // ----------------------------------------------------------------
    localparam int BIT_READY = 7;
    localparam int BIT_ERASE_SUSP = 6;
    localparam int BIT_ERASE_ERR = 5;
    localparam int BIT_WRITE_ERR = 4;
    localparam int BIT_SUPPLY_ERR = 3;
    localparam int BIT_WRITE_SUSP = 2;
    localparam int BIT_PROTECT = 1;

    // ----------------------------------------------------------------
    // Controller registers (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int OP_W = 3;
    localparam int CTRL_ALT = 3;
    localparam int CTRL_PDOWN = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_DONE = 9;
    localparam int ST_SEQERR = 10;
    localparam int ST_STS = 11;
    localparam int ST_PDOWN = 12;

    typedef enum logic [OP_W-1:0] {
        OP_NONE = 3'h0,
        OP_ERASE = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_SUSPEND = 3'h3,
        OP_RESUME = 3'h4,
        OP_READ = 3'h5,
        OP_STATUS = 3'h6,
        OP_CLEAR = 3'h7
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_PRE_CMD = 3'b001,
        S_PRE_RD = 3'b010,
        S_CMD1 = 3'b011,
        S_CMD2 = 3'b100,
        S_POLL = 3'b101,
        S_ARRAY_RD = 3'b110
    } seq_state_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ACT = 2'b01,
        PH_HOLD = 2'b10
    } phase_t;

    // ----------------------------------------------------------------
    // Bus cycle timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_WE_PULSE_NS = 100;
    localparam int T_RECOVER_NS = 30;
    localparam int T_READ_ACCESS_NS = 120;
    localparam int SYNC_STAGES = 2;

    function automatic int ns_to_cyc_up(int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc_up

    localparam int WE_PULSE_CYC = ns_to_cyc_up(T_WE_PULSE_NS);
    localparam int RECOVER_CYC = ns_to_cyc_up(T_RECOVER_NS);
    localparam int READ_CYC = ns_to_cyc_up(T_READ_ACCESS_NS) + SYNC_STAGES;

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

endpackage : flash_host_pkg
`default_nettype wire

// file: flash_cycle_if.sv
// Request channel between the command sequencer and the bus cycle engine.
`timescale 1ns/1ns
`default_nettype none
interface flash_cycle_if #(parameter int AW = 21, parameter int DW = 16) ();
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic done;
    logic busy;
    logic [DW-1:0] rdata;
    modport master(output req, output wr, output addr, output wdata, input done, input busy, input rdata);
    modport engine(input req, input wr, input addr, input wdata, output done, output busy, output rdata);
endinterface : flash_cycle_if
`default_nettype wire

// file: flash_bus_cycle.sv
// Single flash read or write cycle on the parallel pins.
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle import flash_host_pkg::*; #(
    parameter int AW = 21,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Request channel
    flash_cycle_if.engine cyc,
    // Flash pins
    input wire logic [DW-1:0] dq_in,
    output logic [AW-1:0] pin_addr,
    output logic [DW-1:0] pin_dq_out,
    output logic pin_dq_oe,
    output logic pin_ce_n,
    output logic pin_we_n,
    output logic pin_oe_n
);

    typedef struct packed {
        phase_t ph;
        logic [7:0] cnt;
        logic wr;
        logic done;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [DW-1:0] dq_s1;
        logic [DW-1:0] dq_s2;
        logic [DW-1:0] rdata;
    } eng_t;

    eng_t q;
    eng_t d;

    // ----------------------------------------------------------------
    // Cycle sequencing
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.dq_s1 = dq_in;
        d.dq_s2 = q.dq_s1;
        case (q.ph)
            PH_IDLE: begin
                // Done still high means the master has not yet dropped req
                if (cyc.req && !q.done) begin
                    d.ph = PH_ACT;
                    d.cnt = 8'h00;
                    d.wr = cyc.wr;
                    d.addr = cyc.addr;
                    d.dq_out = cyc.wdata;
                    d.dq_oe = cyc.wr;
                    d.ce_n = 1'b0;
                    d.we_n = !cyc.wr;
                    d.oe_n = cyc.wr;
                end
            end
            PH_ACT: begin
                d.cnt = q.cnt + 8'h01;
                if (q.wr && q.cnt == 8'(WE_PULSE_CYC - 1)) begin
                    // Both enables rise together; data stays driven through hold
                    d.we_n = 1'b1;
                    d.ce_n = 1'b1;
                    d.ph = PH_HOLD;
                    d.cnt = 8'h00;
                end else if (!q.wr && q.cnt == 8'(READ_CYC - 1)) begin
                    d.rdata = q.dq_s2;
                    d.ce_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.ph = PH_HOLD;
                    d.cnt = 8'h00;
                end
            end
            PH_HOLD: begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == 8'(RECOVER_CYC - 1)) begin
                    d.dq_oe = 1'b0;
                    d.done = 1'b1;
                    d.ph = PH_IDLE;
                end
            end
            default: begin
                d.ph = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cyc.done = q.done;
    assign cyc.busy = (q.ph != PH_IDLE) || q.done;
    assign cyc.rdata = q.rdata;
    assign pin_addr = q.addr;
    assign pin_dq_out = q.dq_out;
    assign pin_dq_oe = q.dq_oe;
    assign pin_ce_n = q.ce_n;
    assign pin_we_n = q.we_n;
    assign pin_oe_n = q.oe_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_WRITE_NEEDS_CE: assert property (@(posedge mclk) disable iff (reset)
        !q.we_n |-> !q.ce_n)
        else $error("write enable low without chip enable");
    AST_WRITE_PULSE_LEN: assert property (@(posedge mclk) disable iff (reset)
        $rose(q.we_n) |-> $past(q.cnt) == 8'(WE_PULSE_CYC - 1))
        else $error("write pulse length wrong");
    AST_DATA_HELD: assert property (@(posedge mclk) disable iff (reset)
        $rose(q.we_n) |-> q.dq_oe && $stable(q.dq_out) && $stable(q.addr))
        else $error("data not held at write enable rise");

endmodule : flash_bus_cycle
`default_nettype wire

// file: flash_host_ctrl.sv
// Wishbone controlled command sequencer driving a parallel flash.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl import flash_host_pkg::*; #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Flash pins
    output logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic flash_rpd_n,
    input wire logic flash_sts
);

    typedef struct packed {
        seq_state_t st;
        seq_state_t after;
        op_t op;
        logic once;
        logic [DATA_W-1:0] c1;
        logic [DATA_W-1:0] c2;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic alt;
        logic pdown;
        logic rpd_n;
        logic req;
        logic wr;
        logic [ADDR_W-1:0] req_addr;
        logic [DATA_W-1:0] req_wdata;
        logic [7:0] status;
        logic [DATA_W-1:0] rdata;
        logic done_flag;
        logic sts_s1;
        logic sts_s2;
        logic ack;
        logic [31:0] rdat;
    } seq_t;

    seq_t q;
    seq_t d;
    logic acc;
    logic [31:0] wm;
    logic rd_ready;
    logic [7:0] req_cmd;

    flash_cycle_if #(.AW(ADDR_W), .DW(DATA_W)) cyc ();

    function automatic logic [DATA_W-1:0] cmd_word(logic [7:0] c);
        return {{(DATA_W-8){1'b0}}, c};
    endfunction : cmd_word

    function automatic seq_t launch(seq_t s, logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
        s.req = 1'b1;
        s.wr = w;
        s.req_addr = a;
        s.req_wdata = v;
        return s;
    endfunction : launch

    // ----------------------------------------------------------------
    // Register access and command sequencing
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        acc = wb_cyc_i && wb_stb_i && !q.ack;
        wm = 32'h0000_0000;
        d.ack = acc;
        d.sts_s1 = flash_sts;
        d.sts_s2 = q.sts_s1;
        d.rpd_n = !q.pdown;
        if (acc && !wb_we_i) begin
            d.rdat = 32'h0000_0000;
            case (wb_adr_i)
                REG_CTRL: begin
                    d.rdat[CTRL_ALT] = q.alt;
                    d.rdat[CTRL_PDOWN] = q.pdown;
                end
                REG_ADDR: d.rdat = 32'(q.addr);
                REG_DATA: d.rdat = 32'(q.data);
                REG_STATUS: begin
                    d.rdat[7:0] = q.status;
                    d.rdat[ST_BUSY] = q.st != S_IDLE;
                    d.rdat[ST_DONE] = q.done_flag;
                    d.rdat[ST_SEQERR] = q.status[BIT_WRITE_ERR] && q.status[BIT_ERASE_ERR];
                    d.rdat[ST_STS] = q.sts_s2;
                    d.rdat[ST_PDOWN] = q.pdown;
                end
                REG_RDATA: d.rdat = 32'(q.rdata);
                default: d.rdat = 32'h0000_0000;
            endcase
        end
        if (acc && wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    wm = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                    d.alt = wm[CTRL_ALT];
                    d.pdown = wm[CTRL_PDOWN];
                    // Ops are dropped while busy, powered down or a stray cycle drains
                    if (q.st == S_IDLE && !wm[CTRL_PDOWN] && q.rpd_n && !cyc.busy) begin
                        d.op = op_t'(wm[OP_W-1:0]);
                        d.once = 1'b0;
                        d.after = S_POLL;
                        d.c1 = cmd_word(CMD_CHIP_ERASE);
                        d.c2 = cmd_word(CMD_CONFIRM);
                        case (op_t'(wm[OP_W-1:0]))
                            OP_ERASE: d.st = S_PRE_CMD;
                            OP_PROGRAM: begin
                                d.c1 = cmd_word(wm[CTRL_ALT] ? CMD_PROGRAM_ALT : CMD_PROGRAM);
                                d.c2 = q.data;
                                d.st = S_PRE_CMD;
                            end
                            OP_SUSPEND: begin
                                d.c2 = cmd_word(CMD_SUSPEND);
                                d.st = S_CMD2;
                            end
                            OP_RESUME: begin
                                d.after = S_IDLE;
                                d.st = S_CMD2;
                            end
                            OP_READ: begin
                                d.c2 = cmd_word(CMD_READ_ARRAY);
                                d.after = S_ARRAY_RD;
                                d.st = S_CMD2;
                            end
                            OP_STATUS: begin
                                d.c2 = cmd_word(CMD_READ_STATUS);
                                d.once = 1'b1;
                                d.st = S_CMD2;
                            end
                            OP_CLEAR: begin
                                d.c2 = cmd_word(CMD_CLEAR_STATUS);
                                d.after = S_IDLE;
                                d.st = S_CMD2;
                            end
                            default: d.st = S_IDLE;
                        endcase
                    end
                end
                REG_ADDR: begin
                    wm = merge(32'(q.addr), wb_dat_i, wb_sel_i);
                    d.addr = wm[ADDR_W-1:0];
                end
                REG_DATA: begin
                    wm = merge(32'(q.data), wb_dat_i, wb_sel_i);
                    d.data = wm[DATA_W-1:0];
                end
                REG_STATUS: begin
                    if (wb_sel_i[1] && wb_dat_i[ST_DONE]) begin
                        d.done_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        case (q.st)
            S_IDLE: begin
            end
            S_PRE_CMD: begin
                if (!q.req) begin
                    d = launch(d, 1'b1, q.addr, cmd_word(CMD_READ_STATUS));
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.st = S_PRE_RD;
                end
            end
            S_PRE_RD: begin
                if (!q.req) begin
                    d = launch(d, 1'b0, q.addr, q.req_wdata);
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.status = cyc.rdata[7:0];
                    if (cyc.rdata[BIT_READY]) begin
                        d.st = S_CMD1;
                    end
                end
            end
            S_CMD1: begin
                if (!q.req) begin
                    d = launch(d, 1'b1, q.addr, q.c1);
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.st = S_CMD2;
                end
            end
            S_CMD2: begin
                if (!q.req) begin
                    d = launch(d, 1'b1, q.addr, q.c2);
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.st = q.after;
                    if (q.after == S_IDLE) begin
                        d.done_flag = 1'b1;
                    end
                end
            end
            S_POLL: begin
                if (!q.req) begin
                    d = launch(d, 1'b0, q.addr, q.req_wdata);
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.status = cyc.rdata[7:0];
                    // Poll until ready; a plain status query takes one sample
                    if (cyc.rdata[BIT_READY] || q.once) begin
                        d.st = S_IDLE;
                        d.done_flag = 1'b1;
                    end
                end
            end
            S_ARRAY_RD: begin
                if (!q.req) begin
                    d = launch(d, 1'b0, q.addr, q.req_wdata);
                end else if (cyc.done) begin
                    d.req = 1'b0;
                    d.rdata = cyc.rdata;
                    d.st = S_IDLE;
                    d.done_flag = 1'b1;
                end
            end
            default: d.st = S_IDLE;
        endcase
        // Power-down abandons the sequence; the device ignores the pins anyway
        if (!q.rpd_n) begin
            d.st = S_IDLE;
            d.req = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cyc.req = q.req;
    assign cyc.wr = q.wr;
    assign cyc.addr = q.req_addr;
    assign cyc.wdata = q.req_wdata;
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign flash_rpd_n = q.rpd_n;
    assign rd_ready = cyc.rdata[BIT_READY];
    assign req_cmd = q.req_wdata[7:0];

    flash_bus_cycle #(.AW(ADDR_W), .DW(DATA_W)) u_cycle (
        .mclk(mclk),
        .reset(reset),
        .cyc(cyc.engine),
        .dq_in(flash_dq_in),
        .pin_addr(flash_addr),
        .pin_dq_out(flash_dq_out),
        .pin_dq_oe(flash_dq_oe),
        .pin_ce_n(flash_ce_n),
        .pin_we_n(flash_we_n),
        .pin_oe_n(flash_oe_n)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence cmd1_done_s;
        q.st == S_CMD1 && cyc.done && q.op == OP_PROGRAM;
    endsequence
    sequence cmd2_issue_s;
        ##2 (q.req && q.st == S_CMD2);
    endsequence

    AST_SETUP_AFTER_READY: assert property ($rose(q.st == S_CMD1) |-> $past(rd_ready) && $past(q.st) == S_PRE_RD)
        else $error("setup issued before ready seen");
    AST_ERASE_SETUP_CODE: assert property ((q.st == S_CMD1 && q.req && q.op == OP_ERASE) |-> req_cmd == CMD_CHIP_ERASE)
        else $error("wrong chip erase setup code");
    AST_ERASE_CONFIRM_CODE: assert property ((q.st == S_CMD2 && q.req && q.op == OP_ERASE) |-> req_cmd == CMD_CONFIRM)
        else $error("wrong chip erase confirm code");
    AST_PROGRAM_SAME_ADDR: assert property (cmd1_done_s |-> cmd2_issue_s ##0 q.req_addr == $past(q.req_addr, 2))
        else $error("program data cycle at other address");
    AST_SUSPEND_THEN_POLL: assert property ((q.st == S_CMD2 && cyc.done && q.op == OP_SUSPEND) |=> q.st == S_POLL)
        else $error("suspend not followed by status poll");
    AST_READ_AFTER_ARRAY_CMD: assert property ($rose(q.st == S_ARRAY_RD) |-> $past(req_cmd) == CMD_READ_ARRAY)
        else $error("array read without array-read command");
    AST_RESUME_CODE: assert property ((q.st == S_CMD2 && q.req && q.op == OP_RESUME) |-> req_cmd == CMD_CONFIRM)
        else $error("wrong resume code");
    AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : flash_host_ctrl
`default_nettype wire

// file: flash_device_model.sv
// Behavioural model of the parallel flash on the far side.
`timescale 1ns/1ns
`default_nettype none
module flash_device_model #(
    parameter int BUSY_NS = 3000
) (
    // Flash pins
    input wire logic [20:0] addr,
    input wire logic [15:0] dq,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_powerdown_n,
    output logic [15:0] dq_out,
    output logic status_pin
);
    logic [15:0] mem [16];
    logic [7:0] err = 8'h00;
    logic status_mode = 1'b0;
    logic [1:0] pend = 2'h0;
    logic busy = 1'b0;
    logic [15:0] held = 16'h5A5A;
    // Level mode only; the host never sends a pin configuration
    logic [1:0] sts_cfg = 2'h0;
    logic wr_low;

    // Power-down releases the open-drain pin to its pull-up level
    assign status_pin = (!reset_powerdown_n || sts_cfg != 2'h0) ? 1'b1 : ~busy;
    // Write ends when the first enable rises, even if both rise in one step
    assign wr_low = !ce_n && !we_n;
    assign dq_out = (!ce_n && !oe_n && reset_powerdown_n) ?
        (status_mode ? {8'h00, ~busy, err[6:1], 1'b0} : mem[addr[3:0]]) : held;
    // Released bus never repeats the last value
    always @(posedge oe_n) held = ~held;
    always @(posedge busy) #BUSY_NS busy = 1'b0;

    always @(negedge wr_low or negedge reset_powerdown_n) begin
        if (!reset_powerdown_n) begin
            err = 8'h00;
            status_mode = 1'b0;
            pend = 2'h0;
            // Any running operation is abandoned
            busy = 1'b0;
        end else begin
            if (pend == 2'h1) begin
                if (dq[7:0] == 8'hD0) begin
                    foreach (mem[i]) mem[i] = 16'hFFFF;
                    busy = 1'b1;
                end else begin
                    err[5:4] = 2'h3;
                end
                pend = 2'h0;
            end else if (pend == 2'h2) begin
                mem[addr[3:0]] = dq;
                busy = 1'b1;
                pend = 2'h0;
            end else begin
                status_mode = (dq[7:0] != 8'hFF);
                pend = (dq[7:0] == 8'h30) ? 2'h1 : (dq[7:0] == 8'h40 || dq[7:0] == 8'h10) ? 2'h2 : 2'h0;
                if (dq[7:0] == 8'h50) begin
                    err = 8'h00;
                end
            end
        end
    end
endmodule : flash_device_model
`default_nettype wire

// file: flash_command_sequencer_bench.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_bench import flash_host_pkg::*;;
    logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_rpd_n, flash_sts;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, r, seed;
    logic [20:0] flash_addr;
    logic [15:0] flash_dq_in, flash_dq_out, d;
    logic [31:0] q_v[$], q_m[$];
    int n_fail = 0;
    int check_count = 0;

    flash_host_ctrl flash_host_ctrl_inst (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_rpd_n(flash_rpd_n), .flash_sts(flash_sts));
    // Undriven data lines read back inverted, so a late output enable shows up
    flash_device_model flash_device_model_inst (.addr(flash_addr), .dq(flash_dq_oe ? flash_dq_out : ~flash_dq_out),
        .ce_n(flash_ce_n),
        .we_n(flash_we_n), .oe_n(flash_oe_n), .reset_powerdown_n(flash_rpd_n), .dq_out(flash_dq_in),
        .status_pin(flash_sts));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Reads queue an expected value; a zero mask means poll only
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [31:0] e,
        input logic [31:0] m);
        if (!w) begin
            q_v.push_back(e);
            q_m.push_back(m);
        end
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wb

    task automatic wait_idle;
        r = 32'h0000_0100;
        while (r[8] !== 1'b0) wb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0);
    endtask : wait_idle

    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_v.size() > 0) begin
            if (q_m[0] != 32'h0) begin
                check_count++;
                if ((wb_dat_o & q_m[0]) !== q_v[0]) begin
                    n_fail++;
                    $display("mismatch at %0t: got %h expected %h", $time, wb_dat_o & q_m[0], q_v[0]);
                end
            end
            void'(q_v.pop_front());
            void'(q_m.pop_front());
        end
    end

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        #400000;
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        reset = 1'b1;
        seed = 32'hA60D47A2;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        wb(1'b0, REG_STATUS, 32'h0, 32'h0000_0800, 32'h0000_1F00);
        wb(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0, 32'h0);
        wb(1'b0, 8'h14, 32'h0, 32'h0, 32'hFFFF_FFFF);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            d = seed[15:0];
            wb(1'b1, REG_ADDR, {28'h0, seed[19:16]}, 32'h0, 32'h0);
            wb(1'b1, REG_DATA, {16'h0, d}, 32'h0, 32'h0);
            wb(1'b1, REG_CTRL, {28'h0, i[0], 3'h2}, 32'h0, 32'h0);
            wait_idle();
            wb(1'b0, REG_STATUS, 32'h0, 32'h0000_0280, 32'h0000_02BA);
            wb(1'b1, REG_STATUS, 32'h0000_0200, 32'h0, 32'h0);
            wb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0000_0200);
            wb(1'b1, REG_CTRL, 32'h5, 32'h0, 32'h0);
            wait_idle();
            wb(1'b0, REG_RDATA, 32'h0, {16'h0, d}, 32'h0000_FFFF);
        end
        wb(1'b1, REG_CTRL, 32'h1, 32'h0, 32'h0);
        wait_idle();
        wb(1'b0, REG_STATUS, 32'h0, 32'h0000_0080, 32'h0000_00B8);
        wb(1'b1, REG_CTRL, 32'h5, 32'h0, 32'h0);
        wait_idle();
        wb(1'b0, REG_RDATA, 32'h0, 32'h0000_FFFF, 32'h0000_FFFF);
        for (int k = 3; k < 8; k++) begin
            wb(1'b1, REG_CTRL, k, 32'h0, 32'h0);
            wait_idle();
            wb(1'b0, REG_STATUS, 32'h0, 32'h0000_0080, 32'h0000_0084);
        end
        wb(1'b1, REG_CTRL, 32'h11, 32'h0, 32'h0);
        wb(1'b0, REG_STATUS, 32'h0, 32'h0000_1800, 32'h0000_1900);
        wb(1'b1, REG_CTRL, 32'h0, 32'h0, 32'h0);
        repeat (4) @(posedge mclk);
        wb(1'b1, REG_CTRL, 32'h6, 32'h0, 32'h0);
        wait_idle();
        wb(1'b0, REG_STATUS, 32'h0, 32'h0000_0080, 32'h0000_10BE);
        results();
    end
endmodule : flash_command_sequencer_bench
`default_nettype wire
